// ===== core/lbcd_cfg.svh
`ifndef LBCD_CFG_SVH
`define LBCD_CFG_SVH

// Register byte offsets
`define LBCD_CTRL_OFS    12'h000
`define LBCD_INSTR_OFS   12'h004
`define LBCD_STAT_OFS    12'h008
`define LBCD_WORK_OFS    12'h00c
`define LBCD_FLAGS_OFS   12'h010
`define LBCD_BANK_OFS    12'h014
`define LBCD_PC_OFS      12'h018
`define LBCD_PCHI_OFS    12'h01c
`define LBCD_PROD_OFS    12'h020
`define LBCD_CYC_OFS     12'h024
`define LBCD_GID_OFS     12'h028
// File space window: byte address = base + 4 * f
`define LBCD_FILE_SEL    2'h1

// Flag positions
`define LBCD_FLAG_C      0
`define LBCD_FLAG_NC     1
`define LBCD_FLAG_Z      2
`define LBCD_FLAG_SR     3

// File address of the program counter low byte
`define LBCD_PC_LOW_ADDR 8'h02

// Reset value of the global interrupt disable bit
`define LBCD_GID_RST     1'h1

`endif

// ===== core/lbcd_core.sv
`timescale 1ns/1ps
`include "lbcd_cfg.svh"

module lbcd_core (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        int_event,
    output logic             busy
);
    import lbcd_pkg::*;

    lbcd_state_s_t q;
    lbcd_state_s_t n;

    logic [15:0] op;
    logic [7:0]  lit;
    logic [7:0]  fadr;
    logic [7:0]  fval;
    logic [2:0]  bsel;
    logic        run;
    logic        acc;
    logic        is_file;
    logic [7:0]  res;
    logic [11:0] sum;
    logic        do_dest;
    logic        do_skip;
    logic [31:0] rd;
    logic        bad;

    function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        add8 = {(a[7] == b[7]) && (s[7] != a[7]), (s[7:0] == 8'h00), h[4], s[8], s[7:0]};
    endfunction

    assign op      = q.instr;
    assign lit     = q.instr[7:0];
    assign fadr    = q.instr[7:0];
    assign fval    = q.file_mem[fadr];
    assign bsel    = q.instr[10:8];
    assign run     = (q.st == ST_EXEC) && !q.discard;
    assign acc     = psel && penable;
    assign is_file = (paddr[11:10] == `LBCD_FILE_SEL);
    assign pready  = q.ack;
    assign prdata  = q.prdata;
    assign pslverr = q.err;
    assign busy    = (q.st != ST_IDLE);

    // Read mux and address check
    always_comb begin
        rd  = 32'h0000_0000;
        bad = 1'b0;
        if (is_file) begin
            rd = {24'h00_0000, q.file_mem[paddr[9:2]]};
        end else begin
            unique case (paddr)
                `LBCD_CTRL_OFS:   rd = {31'h0000_0000, q.tbl_internal};
                `LBCD_INSTR_OFS:  rd = {16'h0000, q.instr};
                `LBCD_STAT_OFS:   rd = {29'h0000_0000, q.st == ST_TBLW, q.discard, busy};
                `LBCD_WORK_OFS:   rd = {24'h00_0000, q.working_register};
                `LBCD_FLAGS_OFS:  rd = {28'h000_0000, q.flags};
                `LBCD_BANK_OFS:   rd = {24'h00_0000, q.bank_select};
                `LBCD_PC_OFS:     rd = {16'h0000, q.pc};
                `LBCD_PCHI_OFS:   rd = {24'h00_0000, q.program_counter_high_latch};
                `LBCD_PROD_OFS:   rd = {16'h0000, q.prod};
                `LBCD_CYC_OFS:    rd = {24'h00_0000, q.last_cyc};
                `LBCD_GID_OFS:    rd = {31'h0000_0000, q.global_interrupt_disable};
                default:          bad = 1'b1;
            endcase
        end
        // Register writes other than control are refused while an instruction runs
        if (pwrite && busy && !(paddr == `LBCD_CTRL_OFS)) begin
            bad = 1'b1;
        end
        if (pwrite && (paddr == `LBCD_STAT_OFS || paddr == `LBCD_CYC_OFS)) begin
            bad = 1'b1;
        end
    end

    always_comb begin
        n       = q;
        res     = 8'h00;
        sum     = 12'h000;
        do_dest = 1'b0;
        do_skip = 1'b0;
        n.int_s1 = int_event;
        n.int_s2 = q.int_s1;

        // Bus slave: one wait state, effect at the edge where pready is high
        n.ack = 1'b0;
        n.err = 1'b0;
        if (acc && !q.ack) begin
            n.ack    = 1'b1;
            n.err    = bad;
            n.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        if (acc && q.ack && pwrite && !q.err) begin
            if (is_file) begin
                n.file_mem[paddr[9:2]] = pwdata[7:0];
            end else begin
                unique case (paddr)
                    `LBCD_CTRL_OFS:   n.tbl_internal = pwdata[0];
                    `LBCD_INSTR_OFS: begin
                        n.instr = pwdata[15:0];
                        n.st    = ST_EXEC;
                    end
                    `LBCD_WORK_OFS:   n.working_register = pwdata[7:0];
                    `LBCD_FLAGS_OFS:  n.flags = pwdata[3:0];
                    `LBCD_BANK_OFS:   n.bank_select = pwdata[7:0];
                    `LBCD_PC_OFS:     n.pc = pwdata[15:0];
                    `LBCD_PCHI_OFS:   n.program_counter_high_latch = pwdata[7:0];
                    `LBCD_PROD_OFS:   n.prod = pwdata[15:0];
                    `LBCD_GID_OFS:    n.global_interrupt_disable = pwdata[0];
                    default:          n.err = 1'b0;
                endcase
            end
        end

        unique case (q.st)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                if (q.discard) begin
                    // Prefetched word after a taken skip: dropped, no effect
                    n.discard  = 1'b0;
                    n.last_cyc = 8'h00;
                    n.st       = ST_IDLE;
                end else begin
                    n.pc    = q.pc + 16'h0001;
                    n.extra = 2'h0;
                    n.cyc   = 8'h01;
                    casez (op[15:8])
                        8'b0000_111?: begin
                            sum     = add8(q.working_register, fval, 1'b0);
                            do_dest = 1'b1;
                        end
                        8'b0001_000?: begin
                            sum     = add8(q.working_register, fval, q.flags[`LBCD_FLAG_C]);
                            do_dest = 1'b1;
                        end
                        8'b0000_101?: begin
                            res     = q.working_register & fval;
                            do_dest = 1'b1;
                        end
                        8'b0000_110?: begin
                            res     = q.working_register ^ fval;
                            do_dest = 1'b1;
                        end
                        8'b0010_10??: begin
                            res                = op[9] ? 8'hff : 8'h00;
                            n.file_mem[fadr]   = res;
                            if (!op[8]) begin
                                n.working_register = res;
                            end
                        end
                        8'b0011_0011: do_skip = (fval == 8'h00);
                        8'b1000_0???: n.file_mem[fadr][bsel] = 1'b1;
                        8'b1000_1???: n.file_mem[fadr][bsel] = 1'b0;
                        8'b1001_0???: do_skip = fval[bsel];
                        8'b1001_1???: do_skip = !fval[bsel];
                        8'b0011_1???: n.file_mem[fadr][bsel] = !fval[bsel];
                        8'b1011_0000: n.working_register = lit;
                        8'b1011_0001: begin
                            sum = add8(q.working_register, lit, 1'b0);
                            n.working_register = sum[7:0];
                            n.flags = sum[11:8];
                        end
                        8'b1011_0010: begin
                            sum = add8(lit, ~q.working_register, 1'b1);
                            n.working_register = sum[7:0];
                            n.flags = sum[11:8];
                        end
                        8'b1011_0011: begin
                            n.working_register = q.working_register | lit;
                            n.flags[`LBCD_FLAG_Z] = (n.working_register == 8'h00);
                        end
                        8'b1011_0100: begin
                            n.working_register = q.working_register ^ lit;
                            n.flags[`LBCD_FLAG_Z] = (n.working_register == 8'h00);
                        end
                        8'b1011_0101: begin
                            n.working_register = q.working_register & lit;
                            n.flags[`LBCD_FLAG_Z] = (n.working_register == 8'h00);
                        end
                        8'b1011_0110: begin
                            n.working_register = lit;
                            n.sp    = q.sp - 4'h1;
                            n.pc    = q.stack[q.sp - 4'h1];
                            n.extra = 2'h1;
                        end
                        8'b1011_0111: begin
                            n.stack[q.sp] = q.pc + 16'h0001;
                            n.sp    = q.sp + 4'h1;
                            n.pc    = {q.program_counter_high_latch, lit};
                            n.extra = 2'h1;
                        end
                        8'b1011_1000: n.bank_select[3:0] = op[3:0];
                        8'b1011_101?: n.bank_select[7:4] = op[7:4];
                        8'b1011_1100: n.prod = q.working_register * lit;
                        8'b110?_????: begin
                            n.pc    = {q.pc[15:13], op[12:0]};
                            n.program_counter_high_latch = {q.pc[15:13], op[12:8]};
                            n.extra = 2'h1;
                        end
                        8'b111?_????: begin
                            n.stack[q.sp] = q.pc + 16'h0001;
                            n.sp    = q.sp + 4'h1;
                            n.pc    = {q.pc[15:13], op[12:0]};
                            n.program_counter_high_latch = {q.pc[15:13], op[12:8]};
                            n.extra = 2'h1;
                        end
                        8'b1010_10??: n.extra = (fadr == `LBCD_PC_LOW_ADDR) ? 2'h2 : 2'h1;
                        8'b1010_11??: n.extra = q.tbl_internal ? 2'h0 : 2'h1;
                        8'h00: begin
                            if (lit == 8'h05 || lit == 8'h02) begin
                                n.sp    = q.sp - 4'h1;
                                n.pc    = q.stack[q.sp - 4'h1];
                                n.extra = 2'h1;
                            end
                            if (lit == 8'h05) begin
                                n.global_interrupt_disable = 1'b0;
                            end
                        end
                        default: n.extra = 2'h0;
                    endcase
                    if (sum != 12'h000 || op[15:9] == 7'b0000_111 || op[15:9] == 7'b0001_000) begin
                        res     = sum[7:0];
                        n.flags = sum[11:8];
                    end else if (do_dest) begin
                        n.flags[`LBCD_FLAG_Z] = (res == 8'h00);
                    end
                    if (do_dest) begin
                        if (op[8]) begin
                            n.file_mem[fadr] = res;
                        end else begin
                            n.working_register = res;
                        end
                    end
                    if (do_skip) begin
                        n.pc      = q.pc + 16'h0002;
                        n.extra   = 2'h1;
                        n.discard = 1'b1;
                    end
                    if (op[15:10] == 6'b1010_11 && q.tbl_internal) begin
                        n.st = ST_TBLW;
                    end else if (n.extra != 2'h0) begin
                        n.st = ST_STALL;
                    end else begin
                        n.last_cyc = 8'h01;
                        n.st       = ST_IDLE;
                    end
                end
            end
            ST_STALL: begin
                n.cyc   = q.cyc + 8'h01;
                n.extra = q.extra - 2'h1;
                if (q.extra == 2'h1) begin
                    n.last_cyc = q.cyc + 8'h01;
                    n.st       = ST_IDLE;
                end
            end
            ST_TBLW: begin
                n.cyc = q.cyc + 8'h01;
                if (q.int_s2) begin
                    n.last_cyc = q.cyc + 8'h01;
                    n.st       = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.global_interrupt_disable <= `LBCD_GID_RST;
        end else begin
            q <= n;
        end
    end

    logic [7:0] lit_add;
    logic [7:0] lit_and;
    logic [15:0] lit_mul;
    logic        is_tst;
    logic        is_btsc;
    logic        is_btss;
    assign lit_add = q.working_register + lit;
    assign lit_and = q.working_register & lit;
    assign lit_mul = q.working_register * lit;
    assign is_tst  = run && (op[15:8] == 8'h33);
    assign is_btsc = run && (op[15:11] == 5'b1001_1);
    assign is_btss = run && (op[15:11] == 5'b1001_0);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_skip_two_cycles: assert property (is_tst && fval == 8'h00 |=> q.st == ST_STALL ##1 q.st == ST_IDLE)
        else $error("taken zero-test skip not two cycles");
    chk_skip_drops_word: assert property (q.st == ST_EXEC && q.discard |=>
        q.pc == $past(q.pc) && q.working_register == $past(q.working_register) && q.st == ST_IDLE)
        else $error("prefetched word after a taken skip had an effect");
    chk_btsc_skip_pc: assert property (is_btsc && !fval[bsel] |=> q.pc == $past(q.pc) + 16'h0002)
        else $error("clear bit test did not skip");
    chk_btss_noskip_pc: assert property (is_btss && !fval[bsel] |=>
        q.pc == $past(q.pc) + 16'h0001 && q.st == ST_IDLE)
        else $error("set bit test skipped on clear bit");
    chk_lit_add_result: assert property (run && op[15:8] == 8'hb1 |=> q.working_register == $past(lit_add))
        else $error("literal add result wrong");
    chk_lit_and_result: assert property (run && op[15:8] == 8'hb5 |=> q.working_register == $past(lit_and))
        else $error("literal and result wrong");
    chk_mul_no_flags: assert property (run && op[15:8] == 8'hbc |=>
        q.prod == $past(lit_mul) && $stable(q.flags))
        else $error("multiply wrong or flags moved");
    chk_long_call_target: assert property (run && op[15:8] == 8'hb7 |=>
        q.pc[7:0] == $past(lit) ##1 q.st == ST_IDLE)
        else $error("long call target or length wrong");
    chk_int_return_enable: assert property (run && op == 16'h0005 |=> !q.global_interrupt_disable)
        else $error("interrupt return left interrupts disabled");
    chk_tblw_hold: assert property (q.st == ST_TBLW && !q.int_s2 |=> q.st == ST_TBLW)
        else $error("internal table write ended without event");
    chk_bank_low_load: assert property (run && op[15:8] == 8'hb8 |=>
        q.bank_select[3:0] == $past(op[3:0]) && q.bank_select[7:4] == $past(q.bank_select[7:4]))
        else $error("bank select low nibble load wrong");
    chk_toggle_no_flags: assert property (run && op[15:11] == 5'b0011_1 |=>
        $stable(q.flags) && $stable(q.working_register))
        else $error("bit toggle moved flags or work");

    cov_skip_taken: cover property (is_tst && fval == 8'h00 ##2 q.discard);
    cov_tblw_end: cover property (q.st == ST_TBLW ##1 q.st == ST_IDLE);
    cov_long_call: cover property (run && op[15:8] == 8'hb7);
    cov_table_read_pcl: cover property (run && op[15:10] == 6'b1010_10 && fadr == `LBCD_PC_LOW_ADDR);

endmodule

// ===== core/lbcd_pkg.sv
package lbcd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_STALL,
        ST_TBLW
    } lbcd_state_t;

    typedef struct packed {
        lbcd_state_t           st;
        logic                  ack;
        logic                  err;
        logic [31:0]           prdata;
        logic                  tbl_internal;
        logic [15:0]           instr;
        logic [7:0]            working_register;
        logic [3:0]            flags;
        logic [7:0]            bank_select;
        logic [15:0]           pc;
        logic [7:0]            program_counter_high_latch;
        logic                  global_interrupt_disable;
        logic [15:0]           prod;
        logic [15:0][15:0]     stack;
        logic [3:0]            sp;
        logic [255:0][7:0]     file_mem;
        logic [1:0]            extra;
        logic [7:0]            cyc;
        logic [7:0]            last_cyc;
        logic                  discard;
        logic                  int_s1;
        logic                  int_s2;
    } lbcd_state_s_t;

endpackage

// ===== sim/literal_bit_control_decode_test.sv
`timescale 1ns/1ps
`include "lbcd_cfg.svh"

module literal_bit_control_decode_test;
    logic        clk_sys;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        int_event;
    logic        busy;
    int          miscompares;
    int          total_checks;

    // Byte address of file register 0x10, used as the operand file throughout
    localparam logic [11:0] FA = 12'h440;

    lbcd_core lbcd_core_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .int_event(int_event), .busy(busy)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ev, input logic [31:0] got);
        total_checks++;
        if (got !== ev) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, ev, got);
        end
    endtask

    // One APB transfer; waits for pready under a bounded count
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 50) begin
            miscompares++;
            $display("wrong value pready expected 1 seen %b", pready);
            test_done;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk("write error flag", 32'h0, {31'h0, e});
    endtask

    task rc(input logic [11:0] a, input logic [31:0] ev);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk($sformatf("register %h", a), ev, q);
    endtask

    // Issue one instruction word and optionally wait until busy falls
    task ex(input logic [15:0] op, input logic wt);
        int n;
        n = 0;
        wr(`LBCD_INSTR_OFS, {16'h0, op});
        repeat (2) @(posedge clk_sys);
        while (wt && busy !== 1'b0 && n < 200) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 200) begin
            miscompares++;
            $display("wrong value busy expected 0 seen %b", busy);
            test_done;
        end
    endtask

    // Preload work, file 0x10 and flags, execute, then check all of them and the cycle count
    task run(input logic [15:0] op, input logic [7:0] w0, f0, input logic [3:0] l0,
             input logic [7:0] ew, ef, input logic [3:0] el, input logic [7:0] ec);
        wr(`LBCD_WORK_OFS, {24'h0, w0});
        wr(FA, {24'h0, f0});
        wr(`LBCD_FLAGS_OFS, {28'h0, l0});
        ex(op, 1'b1);
        rc(`LBCD_WORK_OFS, {24'h0, ew});
        rc(FA, {24'h0, ef});
        rc(`LBCD_FLAGS_OFS, {28'h0, el});
        rc(`LBCD_CYC_OFS, {24'h0, ec});
    endtask

    // Conditional skip; a taken skip must swallow the next word issued
    task skp(input logic [15:0] op, input logic [7:0] f0, input logic tk);
        logic [31:0] p0;
        logic [31:0] p1;
        logic        e;
        apb(1'b0, `LBCD_PC_OFS, 32'h0, p0, e);
        run(op, 8'h40, f0, 4'h0, 8'h40, f0, 4'h0, tk ? 8'h02 : 8'h01);
        apb(1'b0, `LBCD_PC_OFS, 32'h0, p1, e);
        chk("pc step", tk ? 32'h2 : 32'h1, (p1 - p0) & 32'hffff);
        if (tk) begin
            ex(16'hb101, 1'b1);
            rc(`LBCD_WORK_OFS, 32'h40);
            rc(`LBCD_CYC_OFS, 32'h0);
        end
    endtask

    task t_literal;
        run(16'hb188, 8'h88, 8'h5a, 4'h0, 8'h10, 8'h5a, 4'hb, 8'h01);
        run(16'hb205, 8'h05, 8'h5a, 4'h8, 8'h00, 8'h5a, 4'h7, 8'h01);
        run(16'hb55c, 8'ha3, 8'h5a, 4'hb, 8'h00, 8'h5a, 4'hf, 8'h01);
        run(16'hb301, 8'h00, 8'h5a, 4'hf, 8'h01, 8'h5a, 4'hb, 8'h01);
        run(16'hb4ff, 8'hff, 8'h5a, 4'h0, 8'h00, 8'h5a, 4'h4, 8'h01);
        run(16'hbc34, 8'h12, 8'h5a, 4'ha, 8'h12, 8'h5a, 4'ha, 8'h01);
        rc(`LBCD_PROD_OFS, 32'h03a8);
    endtask

    task t_file;
        run(16'h0e10, 8'h17, 8'hc2, 4'hf, 8'hd9, 8'hc2, 4'h0, 8'h01);
        run(16'h0f10, 8'h17, 8'hc2, 4'h0, 8'h17, 8'hd9, 4'h0, 8'h01);
        run(16'h1010, 8'h4d, 8'h02, 4'h1, 8'h50, 8'h02, 4'h2, 8'h01);
        run(16'h1110, 8'hff, 8'h00, 4'h1, 8'hff, 8'h00, 4'h7, 8'h01);
        run(16'h0a10, 8'h0f, 8'hf0, 4'h0, 8'h00, 8'hf0, 4'h4, 8'h01);
        run(16'h0b10, 8'h0f, 8'hf3, 4'h9, 8'h0f, 8'h03, 4'h9, 8'h01);
        run(16'h0c10, 8'haa, 8'haa, 4'h3, 8'h00, 8'haa, 4'h7, 8'h01);
        run(16'h0d10, 8'h0f, 8'hf0, 4'h4, 8'h0f, 8'hff, 4'h0, 8'h01);
        run(16'h2810, 8'h12, 8'h34, 4'h0, 8'h00, 8'h00, 4'h0, 8'h01);
        run(16'h2910, 8'h12, 8'h34, 4'h0, 8'h12, 8'h00, 4'h0, 8'h01);
    endtask

    task t_bits;
        run(16'h8710, 8'h00, 8'h0a, 4'h5, 8'h00, 8'h8a, 4'h5, 8'h01);
        run(16'h8f10, 8'h00, 8'hc7, 4'h5, 8'h00, 8'h47, 4'h5, 8'h01);
        run(16'h3c10, 8'h00, 8'h75, 4'ha, 8'h00, 8'h65, 4'ha, 8'h01);
        skp(16'h3310, 8'h00, 1'b1);
        skp(16'h3310, 8'h01, 1'b0);
        skp(16'h9b10, 8'hf7, 1'b1);
        skp(16'h9b10, 8'h08, 1'b0);
        skp(16'h9310, 8'h08, 1'b1);
        skp(16'h9310, 8'hf7, 1'b0);
    endtask

    task t_control;
        ex(16'hb8f5, 1'b1);
        rc(`LBCD_BANK_OFS, 32'h05);
        ex(16'hba9c, 1'b1);
        rc(`LBCD_BANK_OFS, 32'h95);
        wr(`LBCD_PCHI_OFS, 32'h12);
        ex(16'hb734, 1'b1);
        rc(`LBCD_PC_OFS, 32'h1234);
        rc(`LBCD_CYC_OFS, 32'h02);
        run(16'hb677, 8'h00, 8'h5a, 4'h5, 8'h77, 8'h5a, 4'h5, 8'h02);
        rc(`LBCD_GID_OFS, 32'h1);
        ex(16'h0005, 1'b1);
        rc(`LBCD_GID_OFS, 32'h0);
        rc(`LBCD_CYC_OFS, 32'h02);
        ex(16'ha802, 1'b1);
        rc(`LBCD_CYC_OFS, 32'h03);
        ex(16'ha810, 1'b1);
        rc(`LBCD_CYC_OFS, 32'h02);
        wr(`LBCD_PC_OFS, 32'h0);
        ex(16'hc123, 1'b1);
        rc(`LBCD_PC_OFS, 32'h0123);
        rc(`LBCD_PCHI_OFS, 32'h01);
        ex(16'he456, 1'b1);
        rc(`LBCD_PC_OFS, 32'h0456);
        rc(`LBCD_CYC_OFS, 32'h02);
        ex(16'h0002, 1'b1);
        rc(`LBCD_PC_OFS, 32'h0124);
        rc(`LBCD_CYC_OFS, 32'h02);
    endtask

    task t_table;
        logic [31:0] q;
        logic        e;
        wr(`LBCD_CTRL_OFS, 32'h0);
        ex(16'hac10, 1'b1);
        rc(`LBCD_CYC_OFS, 32'h02);
        wr(`LBCD_CTRL_OFS, 32'h1);
        ex(16'hac10, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk("busy during internal table write", 32'h1, {31'h0, busy});
        apb(1'b1, `LBCD_WORK_OFS, 32'h99, q, e);
        chk("write while busy refused", 32'h1, {31'h0, e});
        int_event <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk("busy after interrupt event", 32'h0, {31'h0, busy});
        int_event <= 1'b0;
        rc(`LBCD_STAT_OFS, 32'h0);
        ex(16'h0000, 1'b1);
        rc(`LBCD_CYC_OFS, 32'h01);
        wr(`LBCD_CTRL_OFS, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0, q, e);
        chk("unmapped read refused", 32'h1, {31'h0, e});
        apb(1'b1, `LBCD_STAT_OFS, 32'h1, q, e);
        chk("status write refused", 32'h1, {31'h0, e});
    endtask

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        int_event = 1'b0;
        miscompares = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_literal;
        t_file;
        t_bits;
        t_control;
        t_table;
        test_done;
    end

    initial begin
        #300000;
        miscompares++;
        test_done;
    end
endmodule
